//--- core/asbl_host.sv
`timescale 1ns/1ps
// Contract
// - A write ends at the first rising strobe; data is timed to that edge.
// - Write enable stays high for the whole of every read.
// - In a select-ended write the address is valid by select falling.
// - A write enable pulse with output enable low lasts setup plus float time.
// - The host drives data only once memory outputs have floated.
module asbl_host
  import asbl_pkg::*;
#(
  parameter int AW = ADDR_WIDTH,
  parameter int DW = DATA_WIDTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [LANES-1:0] req_lanes,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  output logic [AW-1:0] mem_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic low_byte_enable_n,
  output logic high_byte_enable_n,
  input wire logic [DW-1:0] mem_data_in,
  output logic [DW-1:0] mem_data_out,
  output logic [LANES-1:0] mem_data_oe_n
);
  // Elaboration check of the shape
  if (AW != ADDR_WIDTH || DW != LANES * LANE_WIDTH) begin : g_bad_shape
    $error("asbl_host supports only a 17-bit address and 16-bit data");
  end

  asbl_state_type state_reg, state_next;
  logic [COUNT_WIDTH-1:0] count_reg, count_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic cs_n_reg, cs_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic [LANES-1:0] be_n_reg, be_n_next;
  logic ready_reg, ready_next;
  logic rsp_reg, rsp_next;
  logic capture, load, drive;
  logic [LANES-1:0] lane_drive;
  logic [LANES-1:0] ask_lanes;

  // Empty lane mask is read as a full word
  assign ask_lanes = (req_lanes == '0) ? '1 : req_lanes;

  // Sequencer next state and strobe levels
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    addr_next = addr_reg;
    cs_n_next = cs_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    be_n_next = be_n_reg;
    ready_next = 1'b0;
    rsp_next = 1'b0;
    capture = 1'b0;
    load = 1'b0;
    drive = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Deselected: memory in standby, pins float
        cs_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        be_n_next = '1;
        ready_next = 1'b1;
        if (req_valid && ready_reg) begin
          ready_next = 1'b0;
          addr_next = req_addr;
          cs_n_next = 1'b0;
          be_n_next = ~ask_lanes;
          if (req_write) begin
            // Output enable stays high so the memory never drives
            oe_n_next = 1'b1;
            we_n_next = 1'b0;
            load = 1'b1;
            drive = 1'b1;
            count_next = COUNT_WIDTH'(WRITE_PULSE_CYCLES);
            state_next = ST_WRITE;
          end else begin
            oe_n_next = 1'b0;
            we_n_next = 1'b1;
            count_next = COUNT_WIDTH'(READ_CYCLES);
            state_next = ST_READ;
          end
        end
      end
      ST_READ: begin
        // Address-paced read: strobes hold still until data settles
        count_next = count_reg - COUNT_ONE;
        if (count_reg == COUNT_ONE) begin
          capture = 1'b1;
          rsp_next = 1'b1;
          cs_n_next = 1'b1;
          oe_n_next = 1'b1;
          be_n_next = '1;
          count_next = COUNT_WIDTH'(FLOAT_CYCLES);
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        // Wait for the memory outputs to float before the next access
        count_next = count_reg - COUNT_ONE;
        if (count_reg == COUNT_ONE) begin
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        // Data held on the pins across the whole pulse
        drive = 1'b1;
        count_next = count_reg - COUNT_ONE;
        if (count_reg == COUNT_ONE) begin
          // Write enable rises first and ends the write
          we_n_next = 1'b1;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Data and address held one cycle past the ending edge
        drive = 1'b0;
        cs_n_next = 1'b1;
        be_n_next = '1;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
        cs_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        be_n_next = '1;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      count_reg <= COUNT_ZERO;
      addr_reg <= '0;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      be_n_reg <= '1;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      addr_reg <= addr_next;
      cs_n_reg <= cs_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      be_n_reg <= be_n_next;
      ready_reg <= ready_next;
      rsp_reg <= rsp_next;
    end
  end

  // Only the enabled lanes carry write data
  assign lane_drive = {LANES{drive}} & (load ? ask_lanes : ~be_n_reg);

  // Byte lane data paths
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    asbl_lane #(
      .WIDTH(LANE_WIDTH)
    ) u_lane (
      .clock(clock),
      .reset_n(reset_n),
      .capture(capture & ~be_n_reg[i]),
      .load(load & ask_lanes[i]),
      .drive(lane_drive[i]),
      .pin_in(mem_data_in[i*LANE_WIDTH +: LANE_WIDTH]),
      .wr_data(req_wdata[i*LANE_WIDTH +: LANE_WIDTH]),
      .rd_data(rsp_rdata[i*LANE_WIDTH +: LANE_WIDTH]),
      .pin_out(mem_data_out[i*LANE_WIDTH +: LANE_WIDTH]),
      .pin_oe_n(mem_data_oe_n[i])
    );
  end

  assign req_ready = ready_reg;
  assign rsp_valid = rsp_reg;
  assign mem_addr = addr_reg;
  assign chip_select_n = cs_n_reg;
  assign output_enable_n = oe_n_reg;
  assign write_enable_n = we_n_reg;
  assign low_byte_enable_n = be_n_reg[LANE_LOW];
  assign high_byte_enable_n = be_n_reg[LANE_HIGH];
endmodule : asbl_host

//--- core/asbl_lane.sv
`timescale 1ns/1ps
// One byte lane of the data pins: capture on read, drive on write
module asbl_lane
  import asbl_pkg::*;
#(
  parameter int WIDTH = LANE_WIDTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic capture,
  input wire logic load,
  input wire logic drive,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data,
  output logic [WIDTH-1:0] pin_out,
  output logic pin_oe_n
);
  logic [WIDTH-1:0] rd_reg, rd_next;
  logic [WIDTH-1:0] out_reg, out_next;
  logic oe_n_reg, oe_n_next;

  // Next values of the lane registers
  always_comb begin
    rd_next = capture ? pin_in : rd_reg;
    out_next = load ? wr_data : out_reg;
    oe_n_next = ~drive;
  end

  // Lane registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rd_reg <= '0;
      out_reg <= '0;
      oe_n_reg <= 1'b1;
    end else begin
      rd_reg <= rd_next;
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign rd_data = rd_reg;
  assign pin_out = out_reg;
  assign pin_oe_n = oe_n_reg;
endmodule : asbl_lane

//--- core/asbl_pkg.sv
package asbl_pkg;
  // Memory shape
  localparam int ADDR_WIDTH = 17;
  localparam int DATA_WIDTH = 16;
  localparam int LANE_WIDTH = 8;
  localparam int LANES = 2;
  localparam int LANE_LOW = 0;
  localparam int LANE_HIGH = 1;
  // Clock period and timing figures in picoseconds
  localparam int CLOCK_PERIOD_PS = 8000;
  localparam int READ_CYCLE_TIME_PS = 12000;
  localparam int WRITE_CYCLE_TIME_PS = 12000;
  localparam int ADDRESS_TO_DATA_PS = 12000;
  localparam int WRITE_PULSE_TIME_PS = 8000;
  localparam int DATA_SETUP_TIME_PS = 6000;
  localparam int WRITE_ENABLE_TO_FLOAT_TIME_PS = 6000;
  localparam int OUTPUT_FLOAT_TIME_PS = 6000;
  // Least times round up to whole cycles, at least one
  function automatic int asbl_cycles_up(input int ps);
    int c;
    c = (ps + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : asbl_cycles_up
  localparam int READ_CYCLES = asbl_cycles_up(ADDRESS_TO_DATA_PS) + 1;
  localparam int FLOAT_CYCLES = asbl_cycles_up(OUTPUT_FLOAT_TIME_PS);
  localparam int WRITE_PULSE_CYCLES_RAW = asbl_cycles_up(WRITE_PULSE_TIME_PS);
  localparam int WRITE_SUM_CYCLES = asbl_cycles_up(
      DATA_SETUP_TIME_PS + WRITE_ENABLE_TO_FLOAT_TIME_PS);
  localparam int WRITE_PULSE_CYCLES =
      (WRITE_SUM_CYCLES > WRITE_PULSE_CYCLES_RAW) ?
      WRITE_SUM_CYCLES : WRITE_PULSE_CYCLES_RAW;
  localparam int COUNT_WIDTH = 4;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 4'h0;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 4'h1;
  // Controller states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_READ = 5'h02,
    ST_TURN = 5'h04,
    ST_WRITE = 5'h08,
    ST_RECOVER = 5'h10
  } asbl_state_type;
endpackage : asbl_pkg

//--- tb/asbl_host_assertions.sv
`timescale 1ns/1ps
// Watches the memory-side strobes of the host
module asbl_host_checker
  import asbl_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic [DATA_WIDTH-1:0] mem_data_out,
  input wire logic [LANES-1:0] mem_data_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  read_we_high_a: assert property (
    !output_enable_n |-> write_enable_n) else $error("write during read");
  host_drive_a: assert property (
    mem_data_oe_n != 2'h3 |-> output_enable_n) else $error("bus clash");
  addr_hold_a: assert property (
    !chip_select_n && !$fell(chip_select_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  we_pulse_a: assert property (
    $fell(write_enable_n) |=> !write_enable_n ##1 write_enable_n)
    else $error("write pulse length wrong");
  data_hold_a: assert property (
    $rose(write_enable_n) |-> !chip_select_n && mem_data_oe_n != 2'h3
    && $stable(mem_data_out)) else $error("data not held at write end");
  lane_map_a: assert property (
    !write_enable_n |->
    mem_data_oe_n == {high_byte_enable_n, low_byte_enable_n})
    else $error("driven lanes differ from byte enables");
  write_select_a: assert property (
    !write_enable_n |-> !chip_select_n && output_enable_n)
    else $error("write without select");
endmodule : asbl_host_checker

bind asbl_host asbl_host_checker u_asbl_host_checker (.clock(clock),
  .reset_n(reset_n), .mem_addr(mem_addr), .chip_select_n(chip_select_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .low_byte_enable_n(low_byte_enable_n),
  .high_byte_enable_n(high_byte_enable_n), .mem_data_out(mem_data_out),
  .mem_data_oe_n(mem_data_oe_n));

//--- tb/asbl_sram_model.sv
`timescale 1ns/1ps
// Behavioural static memory with byte lanes
module asbl_sram_model (
  input wire logic [16:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic [15:0] mem_data_out,
  input wire logic [1:0] mem_data_oe_n,
  output logic [15:0] mem_data_in,
  output logic clash
);
  logic [15:0] mem [0:131071];
  logic [15:0] rd;
  logic [1:0] drv;
  logic [1:0] wr;
  assign rd = mem[mem_addr];
  // Lane drive only in a selected read with its enable low
  assign drv[0] = !chip_select_n && !output_enable_n && write_enable_n
    && !low_byte_enable_n;
  assign drv[1] = !chip_select_n && !output_enable_n && write_enable_n
    && !high_byte_enable_n;
  // Write window is the overlap of the three strobes
  assign wr[0] = !chip_select_n && !write_enable_n && !low_byte_enable_n;
  assign wr[1] = !chip_select_n && !write_enable_n && !high_byte_enable_n;
  // Wire level: host, memory, or a floating inverse pattern
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mem_data_in[i*8+:8] = !mem_data_oe_n[i] ? mem_data_out[i*8+:8] :
        drv[i] ? rd[i*8+:8] : ~rd[i*8+:8];
    end
  end
  // Store at the first rising strobe
  always @(negedge wr[0]) mem[mem_addr][7:0] = mem_data_in[7:0];
  always @(negedge wr[1]) mem[mem_addr][15:8] = mem_data_in[15:8];
  // Sticky flag when both sides drive one lane
  initial clash = 1'h0;
  always @(drv, mem_data_oe_n) if (|(drv & ~mem_data_oe_n)) clash = 1'h1;
endmodule : asbl_sram_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import asbl_pkg::*;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic [16:0] req_addr = 17'h0;
  logic [1:0] req_lanes = 2'h0;
  logic [15:0] req_wdata = 16'h0;
  logic req_ready, rsp_valid, cs_n, oe_n, we_n, lbe_n, hbe_n, clash;
  logic [15:0] rsp_rdata, d_in, d_out, r;
  logic [16:0] m_addr;
  logic [1:0] d_oe_n;
  int mismatches = 0;
  int checked = 0;
  always #4 clock = ~clock;
  asbl_host u_asbl_host (.clock(clock), .reset_n(reset_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_lanes(req_lanes), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(m_addr),
    .chip_select_n(cs_n), .output_enable_n(oe_n), .write_enable_n(we_n),
    .low_byte_enable_n(lbe_n), .high_byte_enable_n(hbe_n),
    .mem_data_in(d_in), .mem_data_out(d_out), .mem_data_oe_n(d_oe_n));
  asbl_sram_model u_asbl_sram_model (.mem_addr(m_addr),
    .chip_select_n(cs_n), .output_enable_n(oe_n), .write_enable_n(we_n),
    .low_byte_enable_n(lbe_n), .high_byte_enable_n(hbe_n),
    .mem_data_out(d_out), .mem_data_oe_n(d_oe_n), .mem_data_in(d_in),
    .clash(clash));
  task final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One request, held until taken; reads wait for the answer
  task xfer(input logic w, input logic [16:0] a, input logic [1:0] l,
      input logic [15:0] d);
    int n;
    @(negedge clock);
    {req_valid, req_write, req_addr, req_lanes, req_wdata} = {1'h1, w, a, l, d};
    n = 0;
    while (req_ready !== 1'h1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'h0;
    while (!w && rsp_valid !== 1'h1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    r = rsp_rdata;
    if (n >= 50) begin
      mismatches++;
      final_report();
    end
  endtask : xfer
  // Full words at both ends of the address range, back to back
  task test_words;
    xfer(1'h1, 17'h0, 2'h3, 16'hA5C3);
    xfer(1'h1, 17'h1FFFF, 2'h0, 16'h5A3C);
    xfer(1'h0, 17'h0, 2'h3, 16'h0);
    check(r, 16'hA5C3);
    xfer(1'h0, 17'h1FFFF, 2'h3, 16'h0);
    check(r, 16'h5A3C);
    $display("test_words done");
  endtask : test_words
  // Single-lane writes leave the other lane alone; single-lane reads check only their own lane
  task test_lanes;
    xfer(1'h1, 17'h100, 2'h3, 16'h1234);
    xfer(1'h1, 17'h100, 2'h1, 16'hABEE);
    xfer(1'h1, 17'h100, 2'h2, 16'h77CD);
    xfer(1'h0, 17'h100, 2'h3, 16'h0);
    check(r, 16'h77EE);
    xfer(1'h0, 17'h100, 2'h1, 16'h0);
    check({8'h0, r[7:0]}, 16'h00EE);
    xfer(1'h0, 17'h100, 2'h2, 16'h0);
    check({8'h0, r[15:8]}, 16'h0077);
    check({15'h0, clash}, 16'h0);
    $display("test_lanes done");
  endtask : test_lanes
  initial begin
    repeat (4) @(negedge clock);
    reset_n = 1'h1;
    test_words();
    test_lanes();
    final_report();
  end
endmodule : testbench
